/* bench/tsc_unit_checker.sv */
// assertion checker for the supervisor call and trap unit
module tsc_unit_checker import tsc_pkg::*; #(
  parameter int XLEN      = 64,
  parameter bit WIDE_IMPL = 1'b1
) (
  // clock and reset
  input wire logic            clk_sys,
  input wire logic            rst,
  // instruction side
  input wire logic            ins_valid,
  input wire logic [31:0]     ins_word,
  input wire logic [31:0]     ins_addr,
  input wire logic [31:0]     msr_in,
  input wire logic [XLEN-1:0] opnd_a,
  input wire logic [XLEN-1:0] opnd_b,
  // results
  input wire logic            svc_take,
  input wire logic            trap_take,
  input wire logic            illegal_take,
  input wire logic [31:0]     count_value,
  input wire logic [31:0]     msr_value,
  input wire logic            link_we,
  input wire logic [31:0]     link_value
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic [31:0] word_q;
  logic [31:0] addr_q;
  logic [31:0] msr_q;
  logic        is_svc;
  logic        is_trd;
  logic        is_tri;

  assign is_svc = ins_valid && ins_word[31:26] == 6'h11;
  assign is_trd = ins_valid && ins_word[31:26] == 6'h1f && ins_word[10:1] == 10'h044;
  assign is_tri = ins_valid && ins_word[31:26] == 6'h02;

  // one-cycle copy of the offer, results refer to it
  always_ff @(posedge clk_sys) begin
    word_q <= ins_word;
    addr_q <= ins_addr;
    msr_q  <= msr_in;
  end

  ////////////////////////////////////////////////////////////
  property p_svc_take; is_svc |=> svc_take; endproperty
  a_svc_take: assert property (p_svc_take) else $error("call not taken");
  property p_svc_none; !is_svc |=> !svc_take; endproperty
  a_svc_none: assert property (p_svc_none) else $error("call pulse without call");
  property p_count; is_svc |=> count_value == {word_q[15:0], msr_q[15:0]}; endproperty
  a_count: assert property (p_count) else $error("count image wrong");
  property p_count_hold; !svc_take |-> $stable(count_value); endproperty
  a_count_hold: assert property (p_count_hold) else $error("count image moved");
  property p_msr; is_svc |=> msr_value == (msr_q & 32'hffff_37ff); endproperty
  a_msr: assert property (p_msr) else $error("state word wrong");
  property p_link; is_svc && ins_word[0] |=> link_we && link_value == addr_q + 32'h4; endproperty
  a_link: assert property (p_link) else $error("link not written");
  property p_nolink; is_svc && !ins_word[0] |=> !link_we; endproperty
  a_nolink: assert property (p_nolink) else $error("link written without link bit");
  property p_trd_eq; is_trd && ins_word[23] && opnd_a == opnd_b |=> trap_take == WIDE_IMPL; endproperty
  a_trd_eq: assert property (p_trd_eq) else $error("equal trap missed");
  property p_trd_lt; is_trd && ins_word[25] && $signed(opnd_a) < $signed(opnd_b) |=> trap_take == WIDE_IMPL;
  endproperty
  a_trd_lt: assert property (p_trd_lt) else $error("signed less trap missed");
  property p_trap_none; (is_trd || is_tri) && ins_word[25:21] == 5'h00 |=> !trap_take; endproperty
  a_trap_none: assert property (p_trap_none) else $error("trap with empty mask");
  property p_tri_eq;
    is_tri && ins_word[23] && opnd_a == {{(XLEN-16){ins_word[15]}}, ins_word[15:0]} |=> trap_take == WIDE_IMPL;
  endproperty
  a_tri_eq: assert property (p_tri_eq) else $error("immediate equal trap missed");
  property p_ill; is_trd || is_tri |=> illegal_take == !WIDE_IMPL; endproperty
  a_ill: assert property (p_ill) else $error("illegal pulse wrong");
endmodule

bind tsc_unit tsc_unit_checker #(.XLEN(XLEN), .WIDE_IMPL(WIDE_IMPL)) i_chk (
  .clk_sys, .rst, .ins_valid, .ins_word, .ins_addr, .msr_in, .opnd_a, .opnd_b, .svc_take,
  .trap_take, .illegal_take, .count_value, .msr_value, .link_we, .link_value
);

/* bench/tsc_unit_tb_top.sv */
// self-checking bench of the supervisor call and trap unit
`include "tsc_cfg.svh"
module tsc_unit_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, ins_word = 32'h0, ins_addr = 32'h1000, msr_in = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ins_valid = 1'b0;
  logic [63:0] opnd_a = 64'h0, opnd_b = 64'h0;
  logic [31:0] s_axi_rdata, fetch_target, count_value, msr_value, link_value;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        svc_take, trap_take, illegal_take, link_we, irq;
  logic        trap_take_narrow, illegal_take_narrow;
  int          n_fail = 0;
  int          n_compared = 0;

  always #5 clk_sys = ~clk_sys;

  tsc_unit i_dut (
    .clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ins_valid, .ins_word, .ins_addr, .msr_in, .opnd_a, .opnd_b, .svc_take, .trap_take,
    .illegal_take, .fetch_target, .count_value, .msr_value, .link_we, .link_value, .irq
  );

  // second copy built as a 32-bit implementation, where both trap ops are illegal
  tsc_unit #(.WIDE_IMPL(1'b0)) i_dut_narrow (
    .clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready (), .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready (), .s_axi_bresp (), .s_axi_bvalid (), .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready (), .s_axi_rdata (), .s_axi_rresp (), .s_axi_rvalid (), .s_axi_rready,
    .ins_valid, .ins_word, .ins_addr, .msr_in, .opnd_a, .opnd_b, .svc_take (),
    .trap_take (trap_take_narrow), .illegal_take (illegal_take_narrow), .fetch_target (), .count_value (),
    .msr_value (), .link_we (), .link_value (), .irq ()
  );

  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (s_axi_bready);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", s_axi_rresp, er);
        s_axi_rready <= 1'b0;
      end
    end while (s_axi_rready);
  endtask

  // result pulses land on the taking edge itself, checked just after it
  task automatic issue(input logic [31:0] w, input logic [31:0] m, input logic [63:0] a, input logic [63:0] b);
    // a call must follow a branch or condition register op: a cr-or no-op goes first
    if (w[31:26] == `TSC_OP_SVC) begin
      @(posedge clk_sys);
      ins_valid <= 1'b1;
      ins_word <= {6'h13, 5'h01, 5'h01, 5'h01, 10'h1c1, 1'b0};
    end
    @(posedge clk_sys);
    ins_valid <= 1'b1;
    ins_word <= w;
    msr_in <= m;
    opnd_a <= a;
    opnd_b <= b;
    ins_addr <= ins_addr + 32'h100;
    @(posedge clk_sys);
    ins_valid <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk(`TSC_REG_BASE0, 32'h0, `TSC_RESP_OKAY);
    rd_chk(`TSC_REG_BASE1, 32'h0001_0000, `TSC_RESP_OKAY);
    rd_chk(`TSC_REG_ENABLE, 32'h0, `TSC_RESP_OKAY);
    axi_wr(`TSC_REG_BASE0, 32'h0004_0000);
    rd_chk(`TSC_REG_BASE0, 32'h0004_0000, `TSC_RESP_OKAY);
    rd_chk(8'h40, 32'h0, `TSC_RESP_SLVERR);
    axi_wr(`TSC_REG_ENABLE, 32'h7);
  endtask

  // all four forms under both vector bases, spare fields toggled
  task automatic t_svc();
    logic [31:0] w, m, tgt;
    logic [6:0]  vector_level_field;
    for (int i = 0; i < 8; i++) begin
      vector_level_field = 7'h55 ^ 7'(i);
      w = {6'h11, 10'h0, {4{i[0]}}, vector_level_field, {3{i[0]}}, i[1], i[0]};
      m = i[2] ? 32'hffff_ffff : 32'hffff_ffbf;
      tgt = (i[2] ? 32'h0001_0000 : 32'h0004_0000) + (i[1] ? 32'h1fe0 : {19'h0, 1'b1, vector_level_field, 5'h00});
      issue(w, m, 64'h0, 64'h0);
      chk("svc_take", svc_take, 1'b1);
      chk("fetch_target", fetch_target, tgt);
      chk("count_value", count_value, {w[15:0], m[15:0]});
      chk("msr_value", msr_value, m & 32'hffff_37ff);
      chk("link_we", link_we, i[0]);
      if (i[0]) chk("link_value", link_value, ins_addr + 32'h4);
      chk("irq", irq, 1'b1);
      axi_wr(`TSC_REG_CLEAR, 32'h1);
      chk("irq", irq, 1'b0);
    end
  endtask

  task automatic t_mask();
    axi_wr(`TSC_REG_ENABLE, 32'h0);
    issue({6'h11, 26'h20}, 32'h0, 64'h0, 64'h0);
    chk("irq", irq, 1'b0);
    rd_chk(`TSC_REG_STATUS, 32'h1, `TSC_RESP_OKAY);
    axi_wr(`TSC_REG_CLEAR, 32'h1);
    rd_chk(`TSC_REG_STATUS, 32'h0, `TSC_RESP_OKAY);
    axi_wr(`TSC_REG_ENABLE, 32'h7);
    issue({6'h12, 26'h0}, 32'h0, 64'h0, 64'h0);
    chk("svc_take", svc_take, 1'b0);
  endtask

  // register form, then immediate form with operand b scrambled
  task automatic trap_case(input logic [4:0] msk, input logic [63:0] a, input logic [63:0] b, input logic e);
    logic [31:0] w, wi;
    w = {6'h1f, 15'h0, 10'h044, 1'b0};
    wi = {6'h02, 10'h0, b[15:0]};
    for (int j = 0; j < 5; j++) begin
      w[25-j] = msk[j];
      wi[25-j] = msk[j];
    end
    issue(w, 32'h0, a, b);
    chk("trap_take", trap_take, e);
    chk("illegal_take", illegal_take, 1'b0);
    chk("illegal_take narrow", illegal_take_narrow, 1'b1);
    chk("trap_take narrow", trap_take_narrow, 1'b0);
    issue(wi, 32'h0, a, ~b);
    chk("trap_take imm", trap_take, e);
    chk("illegal_take imm", illegal_take, 1'b0);
    chk("illegal_take imm narrow", illegal_take_narrow, 1'b1);
    chk("trap_take imm narrow", trap_take_narrow, 1'b0);
  endtask

  task automatic t_trap();
    trap_case(5'h01, '1, 64'h1, 1'b1);
    trap_case(5'h02, '1, 64'h1, 1'b0);
    trap_case(5'h02, 64'h1, '1, 1'b1);
    trap_case(5'h08, '1, 64'h1, 1'b0);
    trap_case(5'h08, 64'h1, '1, 1'b1);
    trap_case(5'h10, '1, 64'h1, 1'b1);
    trap_case(5'h04, '1, '1, 1'b1);
    trap_case(5'h00, 64'h5, 64'h5, 1'b0);
    trap_case(5'h1b, 64'h5, 64'h5, 1'b0);
    trap_case(5'h1f, 64'h5, 64'h5, 1'b1);
    chk("irq", irq, 1'b1);
    rd_chk(`TSC_REG_STATUS, 32'h2, `TSC_RESP_OKAY);
    axi_wr(`TSC_REG_CLEAR, 32'h2);
    chk("irq", irq, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_svc();
    t_mask();
    t_trap();
    complete_run();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    complete_run();
  end
endmodule

/* core/tsc_cfg.svh */
// offsets, field positions, reset values and opcodes of the supervisor call and trap unit
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH

// register byte offsets
`define TSC_REG_STATUS   8'h00
`define TSC_REG_ENABLE   8'h04
`define TSC_REG_CLEAR    8'h08
`define TSC_REG_BASE0    8'h0c
`define TSC_REG_BASE1    8'h10
`define TSC_REG_COUNT    8'h14
`define TSC_REG_TARGET   8'h18
`define TSC_ADDR_MASK    8'hfc

// event bits of status, enable and clear
`define TSC_EV_W         3
`define TSC_EV_SVC       0
`define TSC_EV_TRAP      1
`define TSC_EV_ILL       2

// reset values
`define TSC_BASE0_RST    32'h0000_0000
`define TSC_BASE1_RST    32'h0001_0000
`define TSC_ENABLE_RST   3'h0

// opcodes
`define TSC_OP_SVC       6'h11
`define TSC_OP_TRAPI     6'h02
`define TSC_OP_EXT       6'h1f
`define TSC_XO_TRAPD     10'h044

// vector offsets
`define TSC_ABS_OFFSET   13'h1fe0
`define TSC_OFF_ZEROS    5'h00

// state bit positions, little-endian index of the 32-bit state word
`define TSC_MSR_EE       15
`define TSC_MSR_PR       14
`define TSC_MSR_FE       11
`define TSC_MSR_IP       6

// bus answers and the link step
`define TSC_RESP_OKAY    2'h0
`define TSC_RESP_SLVERR  2'h2
`define TSC_LINK_STEP    32'h0000_0004

`endif

/* core/tsc_cmp_if.sv */
// operand and mask bundle between the unit and its trap comparator
interface tsc_cmp_if #(
  parameter int XLEN = 64
);
  logic [XLEN-1:0] opa;
  logic [XLEN-1:0] opb;
  logic [4:0]      mask;
  logic            hit;

  modport host (
    output opa,
    output opb,
    output mask,
    input  hit
  );

  modport cmp (
    input  opa,
    input  opb,
    input  mask,
    output hit
  );
endinterface

/* core/tsc_pkg.sv */
// types shared by the supervisor call and trap unit
package tsc_pkg;

  // class of the instruction offered this cycle
  typedef enum logic [1:0] {
    K_NONE,
    K_SVC,
    K_TRAPD,
    K_TRAPI
  } tsc_kind_t;

  typedef logic [31:0] tsc_word_t;

endpackage

/* core/tsc_trap_cmp.sv */
// five-way trap condition evaluator
module tsc_trap_cmp import tsc_pkg::*; (
  // operands and mask
  tsc_cmp_if.cmp bus
);

  logic       s_lt;
  logic       s_gt;
  logic       eq;
  logic       u_lt;
  logic       u_gt;
  logic [4:0] cond;

  always_comb begin
    s_lt = $signed(bus.opa) < $signed(bus.opb);
    s_gt = $signed(bus.opa) > $signed(bus.opb);
    eq   = bus.opa == bus.opb;
    u_lt = bus.opa < bus.opb;
    u_gt = bus.opa > bus.opb;
    // mask bit n selects condition n, any selected hit traps
    cond    = {u_gt, u_lt, eq, s_gt, s_lt};
    bus.hit = |(cond & bus.mask);
  end

endmodule

/* core/tsc_unit.sv */
// supervisor call and doubleword trap exception unit with register slave
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`include "tsc_cfg.svh"

module tsc_unit import tsc_pkg::*; #(
  parameter int XLEN      = 64,
  parameter bit WIDE_IMPL = 1'b1
) (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst,
  // register bus
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  // instruction offered by the pipeline
  input  wire logic            ins_valid,
  input  wire logic [31:0]     ins_word,
  input  wire logic [31:0]     ins_addr,
  input  wire logic [31:0]     msr_in,
  input  wire logic [XLEN-1:0] opnd_a,
  input  wire logic [XLEN-1:0] opnd_b,
  // exception results
  output logic                 svc_take,
  output logic                 trap_take,
  output logic                 illegal_take,
  output logic [31:0]          fetch_target,
  output logic [31:0]          count_value,
  output logic [31:0]          msr_value,
  output logic                 link_we,
  output logic [31:0]          link_value,
  // interrupt
  output logic                 irq
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  tsc_cmp_if #(.XLEN(XLEN)) cmp_bus ();

  tsc_trap_cmp u_cmp (
    .bus (cmp_bus.cmp)
  );

  tsc_kind_t   kind;
  logic [5:0]  opcode;
  logic [9:0]  ext_op;
  logic [6:0]  level;
  logic        abs_bit;
  logic        lnk_bit;
  logic [12:0] vec_off;
  tsc_word_t   vec_base;

  tsc_word_t   base0;
  tsc_word_t   base1;

  always_comb begin
    opcode  = ins_word[31:26];
    ext_op  = ins_word[10:1];
    // level sits in bits 20-26, absolute in 30, link in 31
    level   = ins_word[11:5];
    abs_bit = ins_word[1];
    lnk_bit = ins_word[0];
    kind    = K_NONE;
    if (ins_valid) begin
      // the system call shares this opcode and lands here too
      if (opcode == `TSC_OP_SVC) begin
        kind = K_SVC;
      end else if (opcode == `TSC_OP_TRAPI) begin
        kind = K_TRAPI;
      end else if (opcode == `TSC_OP_EXT && ext_op == `TSC_XO_TRAPD) begin
        kind = K_TRAPD;
      end
    end
  end

  // spare fields in bits 16-19 and 27-29 (or the absolute data field)
  // never steer the vector; only level, absolute and the state IP bit do, though the spare bits still go into the count image
  always_comb begin
    if (abs_bit) begin
      vec_off = `TSC_ABS_OFFSET;
    end else begin
      vec_off = {1'b1, level, `TSC_OFF_ZEROS};
    end
    vec_base = msr_in[`TSC_MSR_IP] ? base1 : base0;
  end

  always_comb begin
    cmp_bus.opa  = opnd_a;
    // trap mask lives in bits 6-10, bit 6 selects signed less-than
    cmp_bus.mask = {ins_word[21], ins_word[22], ins_word[23], ins_word[24], ins_word[25]};
    if (kind == K_TRAPI) begin
      cmp_bus.opb = {{(XLEN-16){ins_word[15]}}, ins_word[15:0]};
    end else begin
      cmp_bus.opb = opnd_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // exception results

  logic        next_svc_take;
  logic        next_trap_take;
  logic        next_illegal_take;
  tsc_word_t   next_fetch_target;
  tsc_word_t   next_count_value;
  tsc_word_t   next_msr_value;
  logic        next_link_we;
  tsc_word_t   next_link_value;

  always_comb begin
    next_svc_take     = 1'b0;
    next_trap_take    = 1'b0;
    next_illegal_take = 1'b0;
    next_fetch_target = fetch_target;
    next_count_value  = count_value;
    next_msr_value    = msr_value;
    next_link_we      = 1'b0;
    next_link_value   = link_value;
    unique case (kind)
      K_NONE: begin
      end
      K_SVC: begin
        next_svc_take     = 1'b1;
        next_fetch_target = vec_base + {19'h0, vec_off};
        // instruction low half on top, state low half below
        next_count_value  = {ins_word[15:0], msr_in[15:0]};
        next_msr_value    = msr_in;
        next_msr_value[`TSC_MSR_EE] = 1'b0;
        next_msr_value[`TSC_MSR_PR] = 1'b0;
        next_msr_value[`TSC_MSR_FE] = 1'b0;
        // no exception or condition field is produced here at all
        next_link_we      = lnk_bit;
        if (lnk_bit) begin
          next_link_value = ins_addr + `TSC_LINK_STEP;
        end
      end
      K_TRAPD, K_TRAPI: begin
        if (!WIDE_IMPL) begin
          next_illegal_take = 1'b1;
        end else begin
          next_trap_take = cmp_bus.hit;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      svc_take     <= 1'b0;
      trap_take    <= 1'b0;
      illegal_take <= 1'b0;
      fetch_target <= 32'h0;
      count_value  <= 32'h0;
      msr_value    <= 32'h0;
      link_we      <= 1'b0;
      link_value   <= 32'h0;
    end else begin
      svc_take     <= next_svc_take;
      trap_take    <= next_trap_take;
      illegal_take <= next_illegal_take;
      fetch_target <= next_fetch_target;
      count_value  <= next_count_value;
      msr_value    <= next_msr_value;
      link_we      <= next_link_we;
      link_value   <= next_link_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register slave and interrupt

  logic                 aw_held;
  logic [7:0]           aw_addr;
  logic                 w_held;
  tsc_word_t            w_data;
  logic [3:0]           w_strb;
  logic [`TSC_EV_W-1:0] status;
  logic [`TSC_EV_W-1:0] enable;

  logic                 next_aw_held;
  logic [7:0]           next_aw_addr;
  logic                 next_w_held;
  tsc_word_t            next_w_data;
  logic [3:0]           next_w_strb;
  logic                 next_bvalid;
  logic [1:0]           next_bresp;
  logic                 next_rvalid;
  tsc_word_t            next_rdata;
  logic [1:0]           next_rresp;
  logic [`TSC_EV_W-1:0] next_status;
  logic [`TSC_EV_W-1:0] next_enable;
  tsc_word_t            next_base0;
  tsc_word_t            next_base1;
  logic [`TSC_EV_W-1:0] events;
  logic [`TSC_EV_W-1:0] clr;
  logic [7:0]           wa;
  logic [7:0]           ra;

  function automatic tsc_word_t merge(input tsc_word_t old, input tsc_word_t nw, input logic [3:0] be);
    tsc_word_t res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign irq           = |(status & enable);

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    next_enable  = enable;
    next_base0   = base0;
    next_base1   = base1;
    clr          = '0;
    wa           = aw_addr & `TSC_ADDR_MASK;
    ra           = s_axi_araddr & `TSC_ADDR_MASK;
    events       = '0;
    events[`TSC_EV_SVC]  = next_svc_take;
    events[`TSC_EV_TRAP] = next_trap_take;
    events[`TSC_EV_ILL]  = next_illegal_take;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !s_axi_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `TSC_RESP_OKAY;
      unique case (wa)
        `TSC_REG_ENABLE: next_enable = `TSC_EV_W'(merge({29'h0, enable}, w_data, w_strb));
        `TSC_REG_CLEAR:  clr = w_strb[0] ? w_data[`TSC_EV_W-1:0] : '0;
        `TSC_REG_BASE0:  next_base0 = merge(base0, w_data, w_strb);
        `TSC_REG_BASE1:  next_base1 = merge(base1, w_data, w_strb);
        `TSC_REG_STATUS, `TSC_REG_COUNT, `TSC_REG_TARGET: begin
        end
        default: next_bresp = `TSC_RESP_SLVERR;
      endcase
    end
    // a new event beats a clear landing in the same cycle
    next_status = (status & ~clr) | events;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_axi_rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = `TSC_RESP_OKAY;
      unique case (ra)
        `TSC_REG_STATUS: next_rdata = {29'h0, status};
        `TSC_REG_ENABLE: next_rdata = {29'h0, enable};
        `TSC_REG_CLEAR:  next_rdata = 32'h0;
        `TSC_REG_BASE0:  next_rdata = base0;
        `TSC_REG_BASE1:  next_rdata = base1;
        `TSC_REG_COUNT:  next_rdata = count_value;
        `TSC_REG_TARGET: next_rdata = fetch_target;
        default: begin
          next_rdata = 32'h0;
          next_rresp = `TSC_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_held      <= 1'b0;
      aw_addr      <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
      status       <= '0;
      enable       <= `TSC_ENABLE_RST;
      base0        <= `TSC_BASE0_RST;
      base1        <= `TSC_BASE1_RST;
    end else begin
      aw_held      <= next_aw_held;
      aw_addr      <= next_aw_addr;
      w_held       <= next_w_held;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
      status       <= next_status;
      enable       <= next_enable;
      base0        <= next_base0;
      base1        <= next_base1;
    end
  end

endmodule
